// File: rtl/rotate_left_execute_unit.sv
/*
  Rotate-left execute unit with an APB register file. Software loads an
  instruction word; the unit runs four phases (decode, read, process, write)
  against an external banked data memory and updates accumulator or memory byte, and flags.
  Assumes the data memory answers a read one cycle after mem_rd.
*/
`timescale 1ns/1ps
module rotate_left_execute_unit (
   // Clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [rotate_pkg::APB_AW-1:0]  paddr,
   input  wire logic [rotate_pkg::APB_DW-1:0]  pwdata,
   output logic      [rotate_pkg::APB_DW-1:0]  prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Banked data memory
   output logic      [rotate_pkg::MEM_AW-1:0]  mem_addr,
   output logic                                mem_rd,
   input  wire logic [rotate_pkg::BYTE_W-1:0]  mem_rdata,
   output logic                                mem_wr,
   output logic      [rotate_pkg::BYTE_W-1:0]  mem_wdata
);
   import rotate_pkg::*;

   phase_e            state_ff,   nxt_state;
   logic [15:0]       instr_ff,   nxt_instr;
   logic [7:0]        acc_ff,     nxt_acc;
   logic [FLAG_W-1:0] flags_ff,   nxt_flags;
   logic [3:0]        bank_ff,    nxt_bank;
   logic              ext_ff,     nxt_ext;
   logic [11:0]       index_ff,   nxt_index;
   logic              err_ff,     nxt_err;
   logic              rlc_ff,     nxt_rlc;
   logic              dest_ff,    nxt_dest;
   logic [7:0]        result_ff,  nxt_result;
   logic [11:0]       addr_ff,    nxt_addr;
   logic              rd_ff,      nxt_rd;
   logic              wr_ff,      nxt_wr;
   logic [7:0]        wdata_ff,   nxt_wdata;
   logic [31:0]       prdata_ff,  nxt_prdata;
   logic              pready_ff,  nxt_pready;
   logic              pslverr_ff, nxt_pslverr;
   logic [7:0]        rot_res;
   logic              rot_cout;
   logic              busy;
   logic              apb_done;
   logic [5:0]        opc;
   logic [7:0]        fadr;

   // Shared rotator, fed straight from the memory read data
   rotate_core u_rot (
      .src        (mem_rdata),
      .cin        (flags_ff[FLAG_C]),
      .thru_carry (rlc_ff),
      .result     (rot_res),
      .cout       (rot_cout)
   );

   assign busy     = (state_ff != S_IDLE);
   assign apb_done = psel & penable & pready_ff;
   assign opc      = instr_ff[OPC_HI:OPC_LO];
   assign fadr     = instr_ff[7:0];

   // Next-state logic: APB slave first, execution phases last
   always_comb begin
      nxt_state   = state_ff;
      nxt_instr   = instr_ff;
      nxt_acc     = acc_ff;
      nxt_flags   = flags_ff;
      nxt_bank    = bank_ff;
      nxt_ext     = ext_ff;
      nxt_index   = index_ff;
      nxt_err     = err_ff;
      nxt_rlc     = rlc_ff;
      nxt_dest    = dest_ff;
      nxt_result  = result_ff;
      nxt_addr    = addr_ff;
      nxt_rd      = 1'b0;
      nxt_wr      = 1'b0;
      nxt_wdata   = wdata_ff;
      // One wait state keeps every bus output registered
      nxt_pready  = psel & penable & ~pready_ff;
      nxt_prdata  = 32'h0;
      nxt_pslverr = 1'b0;
      if (nxt_pready) begin
         case (paddr)
            REG_INSTR: nxt_prdata = {16'h0, instr_ff};
            REG_ACC:   nxt_prdata = {24'h0, acc_ff};
            REG_FLAGS: nxt_prdata = {27'h0, flags_ff};
            REG_BANK:  nxt_prdata = {28'h0, bank_ff};
            REG_CFG:   nxt_prdata = {31'h0, ext_ff};
            REG_INDEX: nxt_prdata = {20'h0, index_ff};
            REG_STAT:  nxt_prdata = {30'h0, err_ff, busy};
            default:   nxt_pslverr = 1'b1;
         endcase
         // Register writes during execution would race the datapath
         if (pwrite && busy && paddr != REG_STAT) begin
            nxt_pslverr = 1'b1;
         end
      end
      // Writes take effect only at the completing edge
      if (apb_done && pwrite && !pslverr_ff) begin
         case (paddr)
            REG_INSTR: begin
               nxt_instr = pwdata[15:0];
               nxt_state = S_Q1;
            end
            REG_ACC:   nxt_acc   = pwdata[7:0];
            REG_FLAGS: nxt_flags = pwdata[FLAG_W-1:0];
            REG_BANK:  nxt_bank  = pwdata[3:0];
            REG_CFG:   nxt_ext   = pwdata[CFG_EXT_B];
            REG_INDEX: nxt_index = pwdata[11:0];
            REG_STAT:  if (pwdata[STAT_ERR_B]) nxt_err = 1'b0;
            default:   nxt_err = err_ff;
         endcase
      end
      // Instruction phases; later assignments win, so a set beats a clear
      case (state_ff)
         S_IDLE: begin
         end
         S_Q1: begin
            if (opc == OPC_RLC || opc == OPC_RLNC) begin
               nxt_rlc  = (opc == OPC_RLC);
               nxt_dest = instr_ff[DEST_B];
               if (instr_ff[BANKA_B]) begin
                  nxt_addr = {bank_ff, fadr};
               end else if (ext_ff && fadr <= IDX_LIMIT) begin
                  nxt_addr = index_ff + {4'h0, fadr};
               end else if (fadr <= IDX_LIMIT) begin
                  nxt_addr = {4'h0, fadr};
               end else begin
                  nxt_addr = {ACC_HI_BANK, fadr};
               end
               nxt_rd    = 1'b1;
               nxt_state = S_Q2;
            end else begin
               nxt_err   = 1'b1;
               nxt_state = S_IDLE;
            end
         end
         S_Q2: nxt_state = S_Q3;
         S_Q3: begin
            nxt_result          = rot_res;
            nxt_flags[FLAG_C]   = rot_cout;
            nxt_flags[FLAG_N]   = rot_res[7];
            nxt_flags[FLAG_Z]   = (rot_res == 8'h00);
            if (dest_ff) begin
               nxt_wr    = 1'b1;
               nxt_wdata = rot_res;
            end else begin
               nxt_acc   = rot_res;
            end
            nxt_state = S_Q4;
         end
         S_Q4: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= S_IDLE;
         instr_ff   <= INSTR_RST;
         acc_ff     <= ACC_RST;
         flags_ff   <= FLAGS_RST;
         bank_ff    <= BANK_RST;
         ext_ff     <= 1'b0;
         index_ff   <= INDEX_RST;
         err_ff     <= 1'b0;
         rlc_ff     <= 1'b0;
         dest_ff    <= 1'b0;
         result_ff  <= 8'h00;
         addr_ff    <= 12'h000;
         rd_ff      <= 1'b0;
         wr_ff      <= 1'b0;
         wdata_ff   <= 8'h00;
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         instr_ff   <= nxt_instr;
         acc_ff     <= nxt_acc;
         flags_ff   <= nxt_flags;
         bank_ff    <= nxt_bank;
         ext_ff     <= nxt_ext;
         index_ff   <= nxt_index;
         err_ff     <= nxt_err;
         rlc_ff     <= nxt_rlc;
         dest_ff    <= nxt_dest;
         result_ff  <= nxt_result;
         addr_ff    <= nxt_addr;
         rd_ff      <= nxt_rd;
         wr_ff      <= nxt_wr;
         wdata_ff   <= nxt_wdata;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Outputs straight from flops
   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign mem_addr  = addr_ff;
   assign mem_rd    = rd_ff;
   assign mem_wr    = wr_ff;
   assign mem_wdata = wdata_ff;

   // Checks on the datapath and phase sequence
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   decode_rlc_a: assert property (state_ff == S_Q1 && opc == OPC_RLC |=> rlc_ff && state_ff == S_Q2)
      else $error("rotate-through-carry opcode not decoded");
   rlc_result_a: assert property (state_ff == S_Q3 && rlc_ff
      |=> result_ff == {$past(mem_rdata[6:0]), $past(flags_ff[FLAG_C])})
      else $error("rotate-through-carry result wrong");
   rlc_flags_a: assert property (state_ff == S_Q3 && rlc_ff |=> flags_ff[FLAG_C] == $past(mem_rdata[7])
      && flags_ff[FLAG_DC] == $past(flags_ff[FLAG_DC]) && flags_ff[FLAG_OV] == $past(flags_ff[FLAG_OV])
      && flags_ff[FLAG_N] == result_ff[7] && flags_ff[FLAG_Z] == (result_ff == 8'h00))
      else $error("rotate-through-carry flags wrong");
   dest_sel_a: assert property (state_ff == S_Q3 |=> (dest_ff ? (mem_wr && mem_wdata == result_ff)
      : (!mem_wr && acc_ff == result_ff)))
      else $error("result sent to wrong destination");
   bank_addr_a: assert property (state_ff == S_Q1 && instr_ff[BANKA_B] && (opc == OPC_RLC || opc == OPC_RLNC)
      |=> mem_rd && mem_addr == {$past(bank_ff), $past(fadr)})
      else $error("banked address wrong");
   indexed_a: assert property (state_ff == S_Q1 && !instr_ff[BANKA_B] && ext_ff && fadr <= IDX_LIMIT
      && (opc == OPC_RLC || opc == OPC_RLNC) |=> mem_addr == $past(index_ff) + {4'h0, $past(fadr)})
      else $error("indexed literal offset address wrong");
   rlnc_result_a: assert property (state_ff == S_Q3 && !rlc_ff |=> result_ff == {$past(mem_rdata[6:0]),
      $past(mem_rdata[7])} && flags_ff[FLAG_C] == $past(flags_ff[FLAG_C]))
      else $error("rotate-without-carry result or carry wrong");
   phase_seq_a: assert property (state_ff == S_Q1 && (opc == OPC_RLC || opc == OPC_RLNC)
      |=> state_ff == S_Q2 ##1 state_ff == S_Q3 ##1 state_ff == S_Q4 ##1 state_ff == S_IDLE)
      else $error("instruction phase sequence broken");

   rlc_file_c:  cover property (state_ff == S_Q4 && rlc_ff && dest_ff);
   rlnc_acc_c:  cover property (state_ff == S_Q4 && !rlc_ff && !dest_ff);
   indexed_c:   cover property (state_ff == S_Q1 && !instr_ff[BANKA_B] && ext_ff && fadr <= IDX_LIMIT);
   bad_opc_c:   cover property (state_ff == S_Q1 ##1 err_ff && state_ff == S_IDLE);

endmodule : rotate_left_execute_unit

// File: shared/rotate_pkg.sv
/*
  Shared constants for the rotate-left execute unit: APB register map,
  field positions, reset values, opcodes and the instruction phase states.
  Assumes a 32-bit APB with byte addresses and a 12-bit data memory space.
*/
package rotate_pkg;

   // Bus and datapath widths
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int MEM_AW = 12;
   localparam int BYTE_W = 8;

   // Register byte offsets
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_ACC   = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_BANK  = 8'h0c;
   localparam logic [7:0] REG_CFG   = 8'h10;
   localparam logic [7:0] REG_INDEX = 8'h14;
   localparam logic [7:0] REG_STAT  = 8'h18;

   // Status flag positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;
   localparam int FLAG_W  = 5;

   // Instruction word fields
   localparam int OPC_HI  = 15;
   localparam int OPC_LO  = 10;
   localparam int DEST_B  = 9;
   localparam int BANKA_B = 8;
   localparam logic [5:0] OPC_RLC  = 6'h0d;   // 0011 01
   localparam logic [5:0] OPC_RLNC = 6'h11;   // 0100 01

   // Addressing constants
   localparam logic [7:0]  IDX_LIMIT   = 8'h5f;  // Indexed offsets 0..95
   localparam logic [3:0]  ACC_HI_BANK = 4'hf;   // Upper access bank half
   localparam int          CFG_EXT_B   = 0;
   localparam int          STAT_BUSY_B = 0;
   localparam int          STAT_ERR_B  = 1;

   // Reset values
   localparam logic [15:0] INSTR_RST = 16'h0000;
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic [4:0]  FLAGS_RST = 5'h00;
   localparam logic [3:0]  BANK_RST  = 4'h0;
   localparam logic [11:0] INDEX_RST = 12'h000;

   // Instruction cycle phases
   typedef enum logic [2:0] {S_IDLE, S_Q1, S_Q2, S_Q3, S_Q4} phase_e;

endpackage : rotate_pkg

// File: rtl/rotate_core.sv
/*
  Combinational one-bit left rotator, with or without the carry flag.
  Assumes the caller registers the result and the carry out.
*/
`timescale 1ns/1ps
module rotate_core (
   // Operand
   input  wire logic [7:0] src,
   input  wire logic       cin,
   input  wire logic       thru_carry,
   // Result
   output logic [7:0]      result,
   output logic            cout
);
   import rotate_pkg::*;

   // Bit 7 leaves into carry or wraps round to bit 0
   always_comb begin
      if (thru_carry) begin
         result = {src[6:0], cin};
         cout   = src[7];
      end else begin
         result = {src[6:0], src[7]};
         cout   = cin;
      end
   end

endmodule : rotate_core

// File: dv/data_mem_model.sv
/*
  Banked data memory model at the far side of the rotate unit.
  Assumes the unit samples read data in the cycle after mem_rd.
*/
`timescale 1ns/1ps
module data_mem_model (
   // Clock
   input  wire logic                           pclk,
   // Memory port
   input  wire logic [rotate_pkg::MEM_AW-1:0]  mem_addr,
   input  wire logic                           mem_rd,
   input  wire logic                           mem_wr,
   input  wire logic [rotate_pkg::BYTE_W-1:0]  mem_wdata,
   output logic      [rotate_pkg::BYTE_W-1:0]  mem_rdata
);
   import rotate_pkg::*;
   logic [BYTE_W-1:0] mem [4096];
   logic [BYTE_W-1:0] data_ff  = 8'h00;
   logic              valid_ff = 1'b0;

   // Read data held one cycle; writes land on the pulse
   always @(posedge pclk) begin
      valid_ff <= mem_rd;
      if (mem_rd) begin
         data_ff <= mem[mem_addr];
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end

   // Outside the read slot show junk, so stale data cannot pass
   assign mem_rdata = valid_ff ? data_ff : ~data_ff;
endmodule : data_mem_model

// File: dv/test_rotate_left_execute_unit.sv
/*
  Self-checking bench for the rotate-left execute unit over APB.
  Assumes the memory model answers reads one cycle after mem_rd.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module test_rotate_left_execute_unit;
   import rotate_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, err;
   logic [7:0]  paddr, mem_rdata, mem_wdata;
   logic [31:0] pwdata, prdata, rdat;
   logic [11:0] mem_addr, index_v;
   logic [3:0]  bank_v;
   logic        ext_v;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          rd_cnt, wr_cnt;

   rotate_left_execute_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata));
   data_mem_model i_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Memory pulse counters, cleared per instruction
   always @(posedge pclk) begin
      rd_cnt += int'(mem_rd === 1'b1);
      wr_cnt += int'(mem_wr === 1'b1);
   end

   task wrap_up;
      if (error_cnt == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // One APB transfer; answer taken at the edge pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // Flop outputs still hold their pre-edge value here, so this is the sampled one
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         error_cnt++;
         wrap_up();
      end
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task chk_rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rdat)
   endtask : chk_rd

   // Polls busy; bounded so a stuck unit ends the run
   task wait_idle;
      int k;
      for (k = 0; k < 8; k++) begin
         apb(1'b0, REG_STAT, 32'h0);
         if (rdat[STAT_BUSY_B] === 1'b0) break;
      end
      if (k == 8) begin
         error_cnt++;
         wrap_up();
      end
   endtask : wait_idle

   // Reference result: {flags, result}
   function automatic logic [12:0] rot_ref(input logic [5:0] opc, input logic [7:0] s, input logic [4:0] fl);
      logic [7:0] r;
      logic [4:0] f;
      f = fl;
      if (opc == OPC_RLC) begin
         r = {s[6:0], fl[FLAG_C]};
         f[FLAG_C] = s[7];
      end else begin
         r = {s[6:0], s[7]};
      end
      f[FLAG_N] = r[7];
      f[FLAG_Z] = (r == 8'h00);
      return {f, r};
   endfunction : rot_ref

   // Full instruction: setup, refused write while busy, result checks
   task do_op(input logic [5:0] opc, input logic d, input logic a, input logic [7:0] f,
              input logic [7:0] src, input logic [4:0] fl);
      logic [11:0] ea;
      logic [12:0] ex;
      ea = a ? {bank_v, f} : (f <= IDX_LIMIT) ? (ext_v ? index_v + 12'(f) : {4'h0, f}) : {ACC_HI_BANK, f};
      ex = rot_ref(opc, src, fl);
      i_mem.mem[ea] = src;
      apb(1'b1, REG_BANK, 32'(bank_v));
      apb(1'b1, REG_CFG, 32'(ext_v));
      apb(1'b1, REG_INDEX, 32'(index_v));
      apb(1'b1, REG_FLAGS, 32'(fl));
      apb(1'b1, REG_ACC, 32'h5a);
      `CHK("idle write accepted", 1'b0, err)
      rd_cnt = 0;
      wr_cnt = 0;
      apb(1'b1, REG_INSTR, {16'h0, opc, d, a, f});
      apb(1'b1, REG_ACC, 32'h33);
      `CHK("busy write refused", 1'b1, err)
      wait_idle();
      `CHK("mem reads", 1, rd_cnt)
      `CHK("mem writes", int'(d), wr_cnt)
      `CHK("file reg", d ? ex[7:0] : src, i_mem.mem[ea])
      chk_rd(REG_ACC, d ? 32'h5a : 32'(ex[7:0]), "acc");
      chk_rd(REG_FLAGS, 32'(ex[12:8]), "flags");
   endtask : do_op

   // Main sequence
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      bank_v = 4'h3; ext_v = 1'b0; index_v = 12'hff0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(REG_ACC, 32'(ACC_RST), "acc reset");
      do_op(OPC_RLC, 1'b0, 1'b1, 8'h25, 8'he6, 5'h0a);
      do_op(OPC_RLC, 1'b1, 1'b0, 8'h10, 8'h80, 5'h01);
      do_op(OPC_RLC, 1'b1, 1'b1, 8'hff, 8'h80, 5'h00);
      do_op(OPC_RLNC, 1'b1, 1'b0, 8'h80, 8'hab, 5'h11);
      do_op(OPC_RLNC, 1'b0, 1'b1, 8'h00, 8'h00, 5'h1f);
      ext_v = 1'b1;
      do_op(OPC_RLNC, 1'b1, 1'b0, 8'h5f, 8'h81, 5'h00);
      do_op(OPC_RLC, 1'b0, 1'b0, 8'h60, 8'h7f, 5'h01);
      rd_cnt = 0;
      apb(1'b1, REG_INSTR, 32'h3000);
      wait_idle();
      `CHK("bad opcode flagged", 1'b1, rdat[STAT_ERR_B])
      `CHK("bad opcode reads", 0, rd_cnt)
      // Error bit is write-one-to-clear
      apb(1'b1, REG_STAT, 32'h2);
      chk_rd(REG_STAT, 32'h0, "error cleared");
      apb(1'b0, 8'h1c, 32'h0);
      `CHK("unmapped slverr", 1'b1, err)
      `CHK("unmapped rdata", 32'h0, rdat)
      wrap_up();
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      wrap_up();
   end
endmodule : test_rotate_left_execute_unit
